// [rtl/runtime_misc_pkg.sv]
package runtime_misc_pkg;

    // Bus geometry
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 32;

    // Register word indices; byte address is four times the index
    localparam logic [5:0]  IDX_GROUP_EN5    = 6'h1a;
    localparam logic [5:0]  IDX_RSVD_A       = 6'h1b;
    localparam logic [5:0]  IDX_EDGE_STS     = 6'h1c;
    localparam logic [5:0]  IDX_RSVD_B       = 6'h1d;
    localparam logic [5:0]  IDX_FORCED_CHG   = 6'h1e;
    localparam logic [5:0]  IDX_RATE_MIRROR  = 6'h1f;
    localparam logic [5:0]  IDX_SER1_MIRROR  = 6'h20;
    localparam logic [5:0]  IDX_SER2_MIRROR  = 6'h21;
    localparam logic [5:0]  IDX_ROUTE_CTRL   = 6'h22;

    // Reset values
    localparam logic [7:0]  GROUP_EN5_RST    = 8'h00;
    localparam logic [7:0]  EDGE_STS_RST     = 8'h00;
    localparam logic [7:0]  FORCED_CHG_RST   = 8'h03;
    localparam logic [7:0]  ROUTE_CTRL_RST   = 8'h00;
    localparam logic [7:0]  MIRROR_RST       = 8'h00;

    // Implemented bits; everything else reads as zero
    localparam logic [7:0]  GROUP_EN5_MASK   = 8'hcf;
    localparam logic [7:0]  EDGE_STS_MASK    = 8'h3f;
    localparam logic [7:0]  FORCED_CHG_MASK  = 8'h03;
    localparam logic [7:0]  RATE_MIRROR_MASK = 8'hdf;
    localparam logic [7:0]  SER_MIRROR_MASK  = 8'hcf;
    localparam logic [7:0]  ROUTE_CTRL_MASK  = 8'h80;

    // Field positions
    localparam int          ROUTE_EN_BIT     = 7;
    localparam int          FORCE0_BIT       = 0;
    localparam int          FORCE1_BIT       = 1;

    // Bus responses
    localparam logic [1:0]  RESP_OKAY        = 2'b00;
    localparam logic [1:0]  RESP_SLVERR      = 2'b10;

endpackage

// [rtl/runtime_misc_register_bank.sv]
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// RULE1 - Set enable bits pass pins 5.4-5.7 and fan inputs 1, 2 to group event
// RULE2 - Enable bits 4 and 5 are reserved with no source attached
// RULE3 - Offsets 1B and 1D read all zero and hold nothing
// RULE4 - Edge status bits 0-5 set on any edge of pins 2.1,2.2,4.1,4.3,6.0,6.1
// RULE5 - Writing one clears an edge status bit; writing zero leaves it
// RULE6 - Edge status bits 7 and 6 always read zero
// RULE7 - Group enable and edge status reset to 00 on standby power-on reset
// RULE8 - Forced change register resets to 03 on all three resets
// RULE9 - Software may set forced change bits; writing zero never clears them
// RULE10 - A step pulse with a drive selected clears that drive's forced bit
// RULE11 - Media change flag ORs selected forced bits with external change input
// RULE12 - Read-only mirror of floppy rate register, bit 5 reserved
// RULE13 - Read-only mirror of first serial FIFO control register
// RULE14 - Second serial mirror has same layout, bits 5:4 reserved
// RULE15 - Group event reaches the low-active pin only while routing is enabled
// RULE16 - Each mirror takes the mirrored register's value on every write to it
module runtime_misc_register_bank
    import runtime_misc_pkg::*;
(
    input  wire logic              REF_CLK_I,
    input  wire logic              SYS_RST_I,
    input  wire logic              MAIN_POR_I,
    input  wire logic              BUS_RST_I,
    input  wire logic [ADDR_W-1:0] AWADDR_I,
    input  wire logic              AWVALID_I,
    output logic                   AWREADY_O,
    input  wire logic [DATA_W-1:0] WDATA_I,
    input  wire logic [3:0]        WSTRB_I,
    input  wire logic              WVALID_I,
    output logic                   WREADY_O,
    output logic [1:0]             BRESP_O,
    output logic                   BVALID_O,
    input  wire logic              BREADY_I,
    input  wire logic [ADDR_W-1:0] ARADDR_I,
    input  wire logic              ARVALID_I,
    output logic                   ARREADY_O,
    output logic [DATA_W-1:0]      RDATA_O,
    output logic [1:0]             RRESP_O,
    output logic                   RVALID_O,
    input  wire logic              RREADY_I,
    input  wire logic              PIN_5_4_I,
    input  wire logic              PIN_5_5_I,
    input  wire logic              PIN_5_6_I,
    input  wire logic              PIN_5_7_I,
    input  wire logic              FAN_SPEED_IN_1_I,
    input  wire logic              FAN_SPEED_IN_2_I,
    input  wire logic              PIN_2_1_I,
    input  wire logic              PIN_2_2_I,
    input  wire logic              PIN_4_1_I,
    input  wire logic              PIN_4_3_I,
    input  wire logic              PIN_6_0_I,
    input  wire logic              PIN_6_1_I,
    input  wire logic              HEAD_STEP_N_I,
    input  wire logic              DRIVE_SELECT0_N_I,
    input  wire logic              DRIVE_SELECT1_N_I,
    input  wire logic              MEDIA_CHANGE_IN_N_I,
    input  wire logic              RATE_WR_I,
    input  wire logic [7:0]        RATE_DATA_I,
    input  wire logic              SER1_FCR_WR_I,
    input  wire logic [7:0]        SER1_FCR_DATA_I,
    input  wire logic              SER2_FCR_WR_I,
    input  wire logic [7:0]        SER2_FCR_DATA_I,
    output logic                   GROUP_EVENT_OUT_N_O,
    output logic                   GROUP_EVENT_PIN_N_O,
    output logic                   MEDIA_CHANGE_FLAG_O
);

    // Word index of a byte address; misaligned addresses map nowhere
    function automatic logic [6:0] word_index(input logic [ADDR_W-1:0] addr);
        if (addr[1:0] != 2'b00) begin
            return 7'h7f;
        end
        return {1'b0, addr[ADDR_W-1:2]};
    endfunction

    // True where the index lands on a register of this bank
    function automatic logic is_mapped(input logic [6:0] idx);
        return (idx >= {1'b0, IDX_GROUP_EN5}) && (idx <= {1'b0, IDX_ROUTE_CTRL});
    endfunction

    logic [7:0]        group_en5_reg;
    logic [7:0]        edge_sts_reg;
    logic [7:0]        edge_sts_next;
    logic [7:0]        forced_chg_reg;
    logic [7:0]        forced_chg_next;
    logic [7:0]        route_ctrl_reg;
    logic [7:0]        rate_mirror_reg;
    logic [7:0]        ser1_mirror_reg;
    logic [7:0]        ser2_mirror_reg;
    logic [5:0]        edge_pins;
    logic [5:0]        edge_pins_prev_reg;
    logic              primed_reg;
    logic [5:0]        edge_seen;
    logic              step_prev_reg;
    logic              step_pulse;
    logic [7:0]        group_src;
    logic              group_hit;
    logic [ADDR_W-1:0] awaddr_reg;
    logic              aw_held_reg;
    logic [7:0]        wdata_reg;
    logic              wlane_reg;
    logic              w_held_reg;
    logic              wr_fire;
    logic [6:0]        wr_idx;
    logic              wr_byte;
    logic [6:0]        rd_idx;
    logic [7:0]        rd_byte;

    // Event sources, bits 4 and 5 tied off so the enable can never pass them
    assign group_src = {FAN_SPEED_IN_2_I, FAN_SPEED_IN_1_I, 2'b00, // [RULE2]
                        PIN_5_7_I, PIN_5_6_I, PIN_5_5_I, PIN_5_4_I};
    assign group_hit = |(group_src & group_en5_reg & GROUP_EN5_MASK); // [RULE1]

    // Edge pins in status bit order
    assign edge_pins = {PIN_6_1_I, PIN_6_0_I, PIN_4_3_I, PIN_4_1_I, PIN_2_2_I, PIN_2_1_I};
    // No edge before the first sample, so a high pin at reset is not an event
    assign edge_seen = primed_reg ? (edge_pins ^ edge_pins_prev_reg) : 6'h00;

    // Step pulse is the falling edge of the step line
    assign step_pulse = step_prev_reg & ~HEAD_STEP_N_I;

    // Write happens once both address and data are held
    assign wr_fire = aw_held_reg & w_held_reg & ~BVALID_O;
    assign wr_idx  = word_index(awaddr_reg);
    assign wr_byte = wr_fire & wlane_reg;

    // Edge status: hardware set wins over a same-cycle software clear
    always_comb begin
        edge_sts_next = edge_sts_reg;
        if (wr_byte && wr_idx == {1'b0, IDX_EDGE_STS}) begin
            edge_sts_next = edge_sts_reg & ~wdata_reg; // [RULE5]
        end
        edge_sts_next = (edge_sts_next | {2'b00, edge_seen}) & EDGE_STS_MASK; // [RULE4] [RULE6]
    end

    // Forced change: step clears, a software set in the same cycle wins
    always_comb begin
        forced_chg_next = forced_chg_reg;
        if (step_pulse && !DRIVE_SELECT0_N_I) begin
            forced_chg_next[FORCE0_BIT] = 1'b0; // [RULE10]
        end
        if (step_pulse && !DRIVE_SELECT1_N_I) begin
            forced_chg_next[FORCE1_BIT] = 1'b0; // [RULE10]
        end
        if (wr_byte && wr_idx == {1'b0, IDX_FORCED_CHG}) begin
            forced_chg_next = forced_chg_next | (wdata_reg & FORCED_CHG_MASK); // [RULE9]
        end
    end

    // Pin history for edge and step detection
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            edge_pins_prev_reg <= 6'h00;
            primed_reg         <= 1'b0;
            step_prev_reg      <= 1'b1;
        end else begin
            edge_pins_prev_reg <= edge_pins;
            primed_reg         <= 1'b1;
            step_prev_reg      <= HEAD_STEP_N_I;
        end
    end

    // Standby-domain registers
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            group_en5_reg  <= GROUP_EN5_RST; // [RULE7]
            edge_sts_reg   <= EDGE_STS_RST; // [RULE7]
            route_ctrl_reg <= ROUTE_CTRL_RST;
        end else begin
            edge_sts_reg <= edge_sts_next;
            if (wr_byte && wr_idx == {1'b0, IDX_GROUP_EN5}) begin
                group_en5_reg <= wdata_reg & GROUP_EN5_MASK; // [RULE2]
            end
            if (wr_byte && wr_idx == {1'b0, IDX_ROUTE_CTRL}) begin
                route_ctrl_reg <= wdata_reg & ROUTE_CTRL_MASK;
            end
        end
    end

    // Forced change returns to both drives active on any of the three resets
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I || MAIN_POR_I || BUS_RST_I) begin
            forced_chg_reg <= FORCED_CHG_RST; // [RULE8]
        end else begin
            forced_chg_reg <= forced_chg_next;
        end
    end

    // Mirrors follow writes to the registers they shadow; bus writes ignored
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            rate_mirror_reg <= MIRROR_RST;
            ser1_mirror_reg <= MIRROR_RST;
            ser2_mirror_reg <= MIRROR_RST;
        end else begin
            if (RATE_WR_I) begin
                rate_mirror_reg <= RATE_DATA_I & RATE_MIRROR_MASK; // [RULE12] [RULE16]
            end
            if (SER1_FCR_WR_I) begin
                ser1_mirror_reg <= SER1_FCR_DATA_I & SER_MIRROR_MASK; // [RULE13] [RULE16]
            end
            if (SER2_FCR_WR_I) begin
                ser2_mirror_reg <= SER2_FCR_DATA_I & SER_MIRROR_MASK; // [RULE14] [RULE16]
            end
        end
    end

    // Registered pin outputs, so glitches on the sources never reach the pins
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            GROUP_EVENT_OUT_N_O <= 1'b1;
            GROUP_EVENT_PIN_N_O <= 1'b1;
            MEDIA_CHANGE_FLAG_O <= 1'b0;
        end else begin
            GROUP_EVENT_OUT_N_O <= ~group_hit; // [RULE1]
            GROUP_EVENT_PIN_N_O <= ~(group_hit & route_ctrl_reg[ROUTE_EN_BIT]); // [RULE15]
            MEDIA_CHANGE_FLAG_O <= (~DRIVE_SELECT0_N_I & forced_chg_reg[FORCE0_BIT])
                                 | (~DRIVE_SELECT1_N_I & forced_chg_reg[FORCE1_BIT])
                                 | ~MEDIA_CHANGE_IN_N_I; // [RULE11]
        end
    end

    // Write address and data are taken independently, one write at a time
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            AWREADY_O   <= 1'b1;
            WREADY_O    <= 1'b1;
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= 8'h00;
            wlane_reg   <= 1'b0;
            BVALID_O    <= 1'b0;
            BRESP_O     <= RESP_OKAY;
        end else begin
            if (AWVALID_I && AWREADY_O) begin
                awaddr_reg  <= AWADDR_I;
                aw_held_reg <= 1'b1;
                AWREADY_O   <= 1'b0;
            end
            if (WVALID_I && WREADY_O) begin
                wdata_reg  <= WDATA_I[7:0];
                wlane_reg  <= WSTRB_I[0];
                w_held_reg <= 1'b1;
                WREADY_O   <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                BVALID_O    <= 1'b1;
                BRESP_O     <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
            end
            if (BVALID_O && BREADY_I) begin
                BVALID_O  <= 1'b0;
                AWREADY_O <= 1'b1;
                WREADY_O  <= 1'b1;
            end
        end
    end

    // Read multiplexer; reserved slots hold nothing and read zero
    assign rd_idx = word_index(ARADDR_I);
    always_comb begin
        unique case (rd_idx)
            {1'b0, IDX_GROUP_EN5}:   rd_byte = group_en5_reg;
            {1'b0, IDX_EDGE_STS}:    rd_byte = edge_sts_reg & EDGE_STS_MASK; // [RULE6]
            {1'b0, IDX_FORCED_CHG}:  rd_byte = forced_chg_reg & FORCED_CHG_MASK;
            {1'b0, IDX_RATE_MIRROR}: rd_byte = rate_mirror_reg; // [RULE12]
            {1'b0, IDX_SER1_MIRROR}: rd_byte = ser1_mirror_reg; // [RULE13]
            {1'b0, IDX_SER2_MIRROR}: rd_byte = ser2_mirror_reg; // [RULE14]
            {1'b0, IDX_ROUTE_CTRL}:  rd_byte = route_ctrl_reg;
            default:                 rd_byte = 8'h00; // [RULE3]
        endcase
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            ARREADY_O <= 1'b1;
            RVALID_O  <= 1'b0;
            RDATA_O   <= '0;
            RRESP_O   <= RESP_OKAY;
        end else begin
            if (ARVALID_I && ARREADY_O) begin
                ARREADY_O <= 1'b0;
                RVALID_O  <= 1'b1;
                RDATA_O   <= {24'h000000, rd_byte};
                RRESP_O   <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
            end else if (RVALID_O && RREADY_I) begin
                RVALID_O  <= 1'b0;
                ARREADY_O <= 1'b1;
            end
        end
    end

    // Checks
    sequence s_read_at(logic [5:0] idx);
        ARVALID_I && ARREADY_O && ARADDR_I == {idx, 2'b00};
    endsequence

    property p_group_pass;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        1'b1 |=> GROUP_EVENT_OUT_N_O == !$past(|(group_src & group_en5_reg));
    endproperty
    a_group_pass: assert property (p_group_pass) else $error("group event mismatch"); // [RULE1]

    property p_rsvd_enable;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        group_en5_reg[5:4] == 2'b00;
    endproperty
    a_rsvd_enable: assert property (p_rsvd_enable) else $error("reserved enable set"); // [RULE2]

    property p_rsvd_read;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        (s_read_at(IDX_RSVD_A) or s_read_at(IDX_RSVD_B)) |=> RVALID_O && RDATA_O == 32'h0;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved slot not zero"); // [RULE3]

    property p_edge_set;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        (edge_seen != 6'h00) |=> (edge_sts_reg[5:0] & $past(edge_seen)) == $past(edge_seen);
    endproperty
    a_edge_set: assert property (p_edge_set) else $error("edge not recorded"); // [RULE4]

    property p_edge_clear;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        (wr_byte && wr_idx == {1'b0, IDX_EDGE_STS})
            |=> edge_sts_reg == (($past(edge_sts_reg) & ~$past(wdata_reg))
                                 | {2'b00, $past(edge_seen)});
    endproperty
    a_edge_clear: assert property (p_edge_clear) else $error("status clear wrong"); // [RULE5]

    property p_edge_top_zero;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        s_read_at(IDX_EDGE_STS) |=> RDATA_O[7:6] == 2'b00
                                    && RDATA_O[5:0] == $past(edge_sts_reg[5:0]);
    endproperty
    a_edge_top_zero: assert property (p_edge_top_zero) else $error("status read wrong"); // [RULE6]

    property p_standby_reset;
        @(posedge REF_CLK_I)
        SYS_RST_I |=> group_en5_reg == 8'h00 && edge_sts_reg == 8'h00 && forced_chg_reg == 8'h03;
    endproperty
    a_standby_reset: assert property (p_standby_reset) else $error("reset value wrong"); // [RULE7]

    property p_forced_reset;
        @(posedge REF_CLK_I)
        (MAIN_POR_I || BUS_RST_I) |=> forced_chg_reg == 8'h03;
    endproperty
    a_forced_reset: assert property (p_forced_reset) else $error("forced reset wrong"); // [RULE8]

    property p_forced_hold;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I || MAIN_POR_I || BUS_RST_I)
        !step_pulse && forced_chg_reg[0] |=> forced_chg_reg[0];
    endproperty
    a_forced_hold: assert property (p_forced_hold) else $error("forced bit lost"); // [RULE9]

    property p_step_clear;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I || MAIN_POR_I || BUS_RST_I)
        step_pulse && !DRIVE_SELECT1_N_I && !(wr_byte && wdata_reg[1])
            |=> !forced_chg_reg[1];
    endproperty
    a_step_clear: assert property (p_step_clear) else $error("step did not clear"); // [RULE10]

    property p_media_flag;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        1'b1 |=> MEDIA_CHANGE_FLAG_O == $past(!MEDIA_CHANGE_IN_N_I
                 || (!DRIVE_SELECT0_N_I && forced_chg_reg[0])
                 || (!DRIVE_SELECT1_N_I && forced_chg_reg[1]));
    endproperty
    a_media_flag: assert property (p_media_flag) else $error("media flag wrong"); // [RULE11]

    property p_pin_gate;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        !route_ctrl_reg[7] |=> GROUP_EVENT_PIN_N_O;
    endproperty
    a_pin_gate: assert property (p_pin_gate) else $error("pin driven while gated"); // [RULE15]

    property p_mirror_track;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        SER2_FCR_WR_I ##1 !SER2_FCR_WR_I [*2]
            |-> ser2_mirror_reg == ($past(SER2_FCR_DATA_I, 2) & SER_MIRROR_MASK);
    endproperty
    a_mirror_track: assert property (p_mirror_track) else $error("mirror not held"); // [RULE16]

endmodule // runtime_misc_register_bank

// [sim/host_bus_model.sv]
`timescale 1ns/1ps
// Host software at the far side of the register bus; one write and one read at a time
module host_bus_model (
    input  wire logic        clk_i,
    output logic [7:0]       awaddr_o,
    output logic             awvalid_o,
    input  wire logic        awready_i,
    output logic [31:0]      wdata_o,
    output logic [3:0]       wstrb_o,
    output logic             wvalid_o,
    input  wire logic        wready_i,
    input  wire logic [1:0]  bresp_i,
    input  wire logic        bvalid_i,
    output logic             bready_o,
    output logic [7:0]       araddr_o,
    output logic             arvalid_o,
    input  wire logic        arready_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic [1:0]  rresp_i,
    input  wire logic        rvalid_i,
    output logic             rready_o
);
    // Idle bus from time zero
    initial begin
        {awaddr_o, araddr_o, wdata_o, wstrb_o} = '0;
        {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = '0;
    end

    // Address and data go out together; released payload is inverted so no one leans on it
    task automatic write_word(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_left;
        logic w_left;
        @(posedge clk_i);
        awaddr_o  <= a;
        wdata_o   <= d;
        wstrb_o   <= 4'hf;
        awvalid_o <= 1'b1;
        wvalid_o  <= 1'b1;
        bready_o  <= 1'b1;
        aw_left = 1'b1;
        w_left = 1'b1;
        while (aw_left || w_left) begin
            @(posedge clk_i);
            if (aw_left && awready_i) begin
                aw_left = 1'b0;
                awvalid_o <= 1'b0;
                awaddr_o  <= ~a;
            end
            if (w_left && wready_i) begin
                w_left = 1'b0;
                wvalid_o <= 1'b0;
                wdata_o  <= ~d;
            end
        end
        while (!bvalid_i) @(posedge clk_i);
        r = bresp_i;
        bready_o <= 1'b0;
    endtask

    // Read: hold the address until taken, then wait for the data
    task automatic read_word(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        araddr_o  <= a;
        arvalid_o <= 1'b1;
        rready_o  <= 1'b1;
        do @(posedge clk_i); while (!arready_i);
        arvalid_o <= 1'b0;
        araddr_o  <= ~a;
        while (!rvalid_i) @(posedge clk_i);
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
    endtask
endmodule // host_bus_model

// [sim/tb.sv]
`timescale 1ns/1ps
// Bench with a reference model of the bank, compared at every result
module tb
    import runtime_misc_pkg::*;
;
    logic        clk = 1'b0, rst = 1'b1, main_por = 1'b0, bus_rst = 1'b0;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  src = 8'h00;
    logic [5:0]  edg = 6'h00;
    logic        step_n = 1'b1, ds0_n = 1'b1, ds1_n = 1'b1, chg_n = 1'b1;
    logic        rate_wr = 1'b0, s1_wr = 1'b0, s2_wr = 1'b0;
    logic [7:0]  rate_d = 8'h00, s1_d = 8'h00, s2_d = 8'h00;
    logic        ev_out_n, ev_pin_n, media_flag;
    logic [23:0] rnd;
    int          mdl [int];
    int          n_fail = 0, n_tests = 0, cycles = 0;

    always #50 clk = ~clk;

    host_bus_model host_bus_model_inst (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid),
        .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
        .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
        .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
        .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));

    runtime_misc_register_bank runtime_misc_register_bank_inst (.REF_CLK_I(clk),
        .SYS_RST_I(rst), .MAIN_POR_I(main_por), .BUS_RST_I(bus_rst), .AWADDR_I(awaddr),
        .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
        .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
        .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
        .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
        .PIN_5_4_I(src[0]), .PIN_5_5_I(src[1]), .PIN_5_6_I(src[2]), .PIN_5_7_I(src[3]),
        .FAN_SPEED_IN_1_I(src[6]), .FAN_SPEED_IN_2_I(src[7]), .PIN_2_1_I(edg[0]),
        .PIN_2_2_I(edg[1]), .PIN_4_1_I(edg[2]), .PIN_4_3_I(edg[3]), .PIN_6_0_I(edg[4]),
        .PIN_6_1_I(edg[5]), .HEAD_STEP_N_I(step_n), .DRIVE_SELECT0_N_I(ds0_n),
        .DRIVE_SELECT1_N_I(ds1_n), .MEDIA_CHANGE_IN_N_I(chg_n), .RATE_WR_I(rate_wr),
        .RATE_DATA_I(rate_d), .SER1_FCR_WR_I(s1_wr), .SER1_FCR_DATA_I(s1_d),
        .SER2_FCR_WR_I(s2_wr), .SER2_FCR_DATA_I(s2_d), .GROUP_EVENT_OUT_N_O(ev_out_n),
        .GROUP_EVENT_PIN_N_O(ev_pin_n), .MEDIA_CHANGE_FLAG_O(media_flag));

    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under two thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Model state after the standby reset; only mapped words exist
    task automatic mdl_reset();
        for (int i = 'h1a; i <= 'h22; i++) mdl[i] = 0;
        mdl['h1e] = 3;
    endtask

    // Bus write plus the model's view of what it does
    task automatic reg_wr(input int idx, input logic [7:0] d);
        logic [1:0] r;
        host_bus_model_inst.write_word(8'(idx * 4), {24'h0, d}, r);
        chk("bresp", 32'(r), 32'(mdl.exists(idx) ? RESP_OKAY : RESP_SLVERR));
        case (idx)
            'h1a: mdl[idx] = d & 8'hcf;
            'h1c: mdl[idx] = mdl[idx] & ~d;
            'h1e: mdl[idx] = mdl[idx] | (d & 8'h03);
            'h22: mdl[idx] = d & 8'h80;
            default: ;
        endcase
    endtask

    task automatic reg_rd(input int idx);
        logic [31:0] d;
        logic [1:0]  r;
        host_bus_model_inst.read_word(8'(idx * 4), d, r);
        chk("rdata", d, mdl.exists(idx) ? 32'(mdl[idx]) : 32'h0);
        chk("rresp", 32'(r), 32'(mdl.exists(idx) ? RESP_OKAY : RESP_SLVERR));
    endtask

    // Pin outputs against the model once registered outputs have settled
    task automatic ev_chk();
        tick(3);
        chk("group_out", 32'(ev_out_n), 32'(!(|(mdl['h1a] & src))));
        chk("group_pin", 32'(ev_pin_n), 32'(!((|(mdl['h1a] & src)) && mdl['h22][7])));
        chk("media", 32'(media_flag), 32'((!ds0_n && mdl['h1e][0]) || (!ds1_n && mdl['h1e][1])
            || !chg_n));
    endtask

    task automatic step_pulse();
        step_n <= 1'b0;
        tick(1);
        step_n <= 1'b1;
        tick(2);
    endtask

    initial begin
        void'($urandom(32'h68a1));
        tick(4);
        rst <= 1'b0;
        mdl_reset();
        // Reset values, reserved words and unmapped neighbours
        for (int i = 'h19; i <= 'h23; i++) reg_rd(i);
        for (int i = 'h1b; i <= 'h21; i++) if (i != 'h1c && i != 'h1e) reg_wr(i, 8'hff);
        for (int i = 'h1b; i <= 'h21; i++) reg_rd(i);
        reg_wr('h1a, 8'($urandom));
        reg_rd('h1a);
        // Each group source alone, odd sources routed and even ones not, reserved enable bits included
        for (int k = 0; k < 8; k++) begin
            reg_wr('h1a, 8'h01 << k);
            reg_wr('h22, k[0] ? 8'h80 : 8'h00);
            src <= 8'h01 << k;
            ev_chk();
            src <= ~(8'h01 << k);
            ev_chk();
        end
        // Rising then falling edge on each status pin; zero writes keep, one writes clear
        for (int k = 0; k < 12; k++) begin
            edg <= edg ^ (6'h01 << (k % 6));
            tick(3);
            mdl['h1c] = mdl['h1c] | (1 << (k % 6));
            reg_wr('h1c, 8'hc0);
            reg_rd('h1c);
            reg_wr('h1c, 8'h01 << (k % 6));
            reg_rd('h1c);
        end
        // Forced change per drive: flag, step clear, external input
        reg_wr('h1e, 8'h00);
        reg_rd('h1e);
        for (int k = 0; k < 2; k++) begin
            ds0_n <= k[0];
            ds1_n <= !k[0];
            ev_chk();
            step_pulse();
            mdl['h1e] = mdl['h1e] & ~(1 << k);
            reg_rd('h1e);
            chg_n <= 1'b0;
            ev_chk();
            chg_n <= 1'b1;
        end
        ds0_n <= 1'b1;
        ds1_n <= 1'b1;
        reg_wr('h1e, 8'h02);
        reg_rd('h1e);
        // Main and bus resets both restore both forced bits
        for (int k = 0; k < 2; k++) begin
            ds0_n <= 1'b0;
            ds1_n <= 1'b0;
            step_pulse();
            ds0_n <= 1'b1;
            ds1_n <= 1'b1;
            mdl['h1e] = 0;
            reg_rd('h1e);
            if (k == 0) main_por <= 1'b1;
            else bus_rst <= 1'b1;
            tick(1);
            main_por <= 1'b0;
            bus_rst <= 1'b0;
            tick(1);
            mdl['h1e] = 3;
            reg_rd('h1e);
        end
        // Mirrors take each written value and ignore data without a write pulse
        for (int k = 0; k < 3; k++) begin
            rnd = 24'($urandom);
            {s2_d, s1_d, rate_d} <= rnd;
            {rate_wr, s1_wr, s2_wr} <= 3'b111;
            tick(1);
            {rate_wr, s1_wr, s2_wr} <= 3'b000;
            {s2_d, s1_d, rate_d} <= ~rnd;
            mdl['h1f] = rnd[7:0] & 8'hdf;
            mdl['h20] = rnd[15:8] & 8'hcf;
            mdl['h21] = rnd[23:16] & 8'hcf;
            for (int i = 'h1f; i <= 'h21; i++) reg_rd(i);
        end
        // Standby reset in mid-run returns the lot to reset values, forced change to 03
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        mdl_reset();
        for (int i = 'h1a; i <= 'h22; i++) reg_rd(i);
        summarize();
    end
endmodule // tb
